// >>> logic/smw_supervisor.sv
//Contract
// - Level mode watches both turn-on and turn-off comparator results.
// - Sixteen threshold codes each for turn-on and turn-off.
// - Eight shutdown hold times and eight shutdown delays selectable.
// - Shutdown hold defaults to 10 ms, delay to 100 ms.
// - Turn-off shutdown latches a fault bit until read or cleared.
// - Warning goes low first; shutdown follows after the delay.
// - Rising-edge mode uses only turn-on result, ignores turn-off.
// - Main monitor: eight thresholds, eight hold times; reset held.
// - Main hold defaults to 200 ms, threshold to the 4.36 V code.
// - Main undervoltage asserts reset; release after hold on recovery.
// - Aux monitor: eight thresholds and eight hold times.
// - Aux threshold defaults to disabled, causing no reset.
// - Aux result drives aux output directly, and reset via hold.
// - Eight watchdog timeouts from 100 ms to 2000 ms.
// - Watchdog timeout defaults to 1500 ms.
// - Watchdog supervises only once reset output is high.
// - No watchdog edge within timeout gives a reset pulse.
// - Standard mode repeats pulses each timeout until an edge.
// - Watchdog timer clears whenever reset is asserted.
// - Advanced: fourth timeout gives shutdown and reset for 1 s.
// - Floating input disables watchdog unless enable bit is set.
// - Float enable writable only if fuse unblown or override set.
// - Shutdown asserted always asserts reset as well.
// - Manual reset has top priority in asserting reset.
`timescale 1ns/10ps
module smw_supervisor
  import smw_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire smw_cmp_s    cmp_i,
  output smw_thr_s         thr_o,
  input  wire logic        watchdog_toggle_in_i,
  input  wire logic        watchdog_float_i,
  input  wire logic        manual_reset_n_i,
  input  wire logic        fuse_float_blown_i,
  output logic             shutdown_out_n_o,
  output logic             shutdown_warning_n_o,
  output logic             reset_out_n_o,
  output logic             aux_comparator_out_o,
  output logic             aux_comparator_out_oe_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    smw_ctrl_s   ctrl;
    smw_wdog_s   wdog;
    logic [1:0]  fault;
    smw_sd_e     sd;
    logic [15:0] pre;
    logic [15:0] sd_cnt;
    logic [15:0] main_cnt;
    logic [15:0] aux_cnt;
    logic [15:0] wd_cnt;
    logic [1:0]  wd_miss;
    logic [15:0] wd_pulse;
    logic        wd_sd;
    logic        wdi_prev;
    logic        ack;
    logic [31:0] dat;
    logic        shutdown_out_n_n;
    logic        warn_n;
    logic        rst_n;
  } smw_state_s;

  // Power-up: shutdown and reset held low
  localparam smw_state_s ST_RST = '{ctrl: CTRL_RST, wdog: WDOG_RST,
    sd: SD_DOWN, sd_cnt: SD_HOLD_TBL[CTRL_RST.sd_hold],
    main_cnt: RST_HOLD_TBL[CTRL_RST.main_hold], warn_n: 1'b1,
    default: '0};

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  smw_state_s s_reg;
  smw_state_s s_next;
  logic       tick;
  logic       req;
  logic       flt_clr;
  logic [1:0] flt_set;
  logic [31:0] wmask;
  logic       wake_trip;
  logic       wd_on;
  logic       wd_edge;
  logic       wd_tmo;
  logic       rst_req;

  // Byte lane mask from select
  function automatic logic [31:0] smw_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next  = s_reg;
    flt_set = '0;
    flt_clr = 1'b0;
    wmask   = smw_mask(wb_sel_i);

    // Free-running time base
    tick = (s_reg.pre == TICK_LAST);
    s_next.pre = tick ? 16'h0000 : s_reg.pre + 16'h0001;

    // Wishbone slave, one wait state
    req = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.ack = req;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          s_next.ctrl = smw_ctrl_s'((s_reg.ctrl & ~wmask) |
                                    (wb_dat_i & wmask));
          s_next.ctrl.rsvd = '0;
        end
        ADR_WDOG: begin
          s_next.wdog = smw_wdog_s'((s_reg.wdog & ~wmask) |
                                    (wb_dat_i & wmask));
          s_next.wdog.rsvd = '0;
          if (fuse_float_blown_i && !s_reg.wdog.fuse_override) begin
            s_next.wdog.float_en = s_reg.wdog.float_en;
          end
        end
        ADR_FAULT: flt_clr = 1'b1;
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL:  s_next.dat = s_reg.ctrl;
        ADR_WDOG:  s_next.dat = s_reg.wdog;
        ADR_STAT:  s_next.dat = {24'h0, s_reg.wd_miss, s_reg.sd,
                                 cmp_i.aux_uv, s_reg.rst_n,
                                 s_reg.warn_n, s_reg.shutdown_out_n_n};
        ADR_FAULT: begin
          s_next.dat = {30'h0, s_reg.fault};
          flt_clr = 1'b1;
        end
        default:   s_next.dat = '0;
      endcase
    end

    // Wake sequencer: warning, delay, shutdown, hold
    wake_trip = s_reg.ctrl.edge_mode ? 1'b0 : cmp_i.wake_off;
    case (s_reg.sd)
      SD_RUN: begin
        if (wake_trip) begin
          s_next.sd = SD_WARN;
          s_next.sd_cnt = SD_DLY_TBL[s_reg.ctrl.sd_delay];
          flt_set[FLT_WAKE] = 1'b1;
        end
      end
      SD_WARN: begin
        if (tick) begin
          if (s_reg.sd_cnt <= 16'h0001) begin
            s_next.sd = SD_DOWN;
            s_next.sd_cnt = SD_HOLD_TBL[s_reg.ctrl.sd_hold];
          end else begin
            s_next.sd_cnt = s_reg.sd_cnt - 16'h0001;
          end
        end
      end
      SD_DOWN: begin
        if (tick && s_reg.sd_cnt != 16'h0000) begin
          s_next.sd_cnt = s_reg.sd_cnt - 16'h0001;
        end
        if (s_reg.sd_cnt == 16'h0000 && cmp_i.wake_on && !wake_trip) begin
          s_next.sd = SD_RUN;
        end
      end
      default: s_next.sd = SD_DOWN;
    endcase

    // Main supply hold timer
    if (cmp_i.main_uv) begin
      s_next.main_cnt = RST_HOLD_TBL[s_reg.ctrl.main_hold];
    end else if (tick && s_reg.main_cnt != 16'h0000) begin
      s_next.main_cnt = s_reg.main_cnt - 16'h0001;
    end

    // Aux supply hold timer, idle while disabled
    if (s_reg.ctrl.aux_thr == AUX_THR_OFF) begin
      s_next.aux_cnt = 16'h0000;
    end else if (cmp_i.aux_uv) begin
      s_next.aux_cnt = RST_HOLD_TBL[s_reg.ctrl.aux_hold];
    end else if (tick && s_reg.aux_cnt != 16'h0000) begin
      s_next.aux_cnt = s_reg.aux_cnt - 16'h0001;
    end

    // Watchdog
    s_next.wdi_prev = watchdog_toggle_in_i;
    wd_edge = (watchdog_toggle_in_i ^ s_reg.wdi_prev) && !watchdog_float_i;
    wd_on   = !(watchdog_float_i && !s_reg.wdog.float_en);
    wd_tmo  = tick && (s_reg.wd_cnt >= WD_TMO_TBL[s_reg.wdog.timeout] -
                       16'h0001);
    if (tick && s_reg.wd_pulse != 16'h0000) begin
      s_next.wd_pulse = s_reg.wd_pulse - 16'h0001;
      if (s_reg.wd_pulse == 16'h0001) begin
        s_next.wd_sd = 1'b0;
      end
    end
    if (!s_reg.rst_n) begin
      s_next.wd_cnt = 16'h0000;
    end else if (!wd_on || wd_edge) begin
      s_next.wd_cnt  = 16'h0000;
      s_next.wd_miss = 2'h0;
    end else if (wd_tmo) begin
      s_next.wd_cnt = 16'h0000;
      flt_set[FLT_WD] = 1'b1;
      if (s_reg.wdog.adv_mode && s_reg.wd_miss == 2'h3) begin
        s_next.wd_sd    = 1'b1;
        s_next.wd_pulse = ONE_SEC_TK;
        s_next.wd_miss  = 2'h0;
      end else begin
        s_next.wd_pulse = WD_PULSE_TK;
        if (s_reg.wdog.adv_mode) begin
          s_next.wd_miss = s_reg.wd_miss + 2'h1;
        end
      end
    end else if (tick) begin
      s_next.wd_cnt = s_reg.wd_cnt + 16'h0001;
    end

    // Fault record: a new event wins over a clear
    s_next.fault = (flt_clr ? 2'h0 : s_reg.fault) | flt_set;

    // Outputs
    s_next.warn_n = (s_next.sd == SD_RUN);
    s_next.shutdown_out_n_n = !(s_next.sd == SD_DOWN || s_next.wd_sd);
    rst_req = !manual_reset_n_i || !s_next.shutdown_out_n_n ||
              cmp_i.main_uv || s_next.main_cnt != 16'h0000 ||
              s_next.aux_cnt != 16'h0000 || s_next.wd_pulse != 16'h0000;
    s_next.rst_n = !rst_req;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Port drive
  assign wb_dat_o             = s_reg.dat;
  assign wb_ack_o             = s_reg.ack;
  assign shutdown_out_n_o     = s_reg.shutdown_out_n_n;
  assign shutdown_warning_n_o = s_reg.warn_n;
  assign reset_out_n_o        = s_reg.rst_n;
  assign aux_comparator_out_o = 1'b0;
  assign aux_comparator_out_oe_o = cmp_i.aux_uv;
  assign thr_o = '{wake_turn_on_threshold:  s_reg.ctrl.on_thr,
                   wake_turn_off_threshold: s_reg.ctrl.off_thr,
                   main_supply_monitor:     s_reg.ctrl.main_thr,
                   aux_supply_monitor:      s_reg.ctrl.aux_thr};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_shutdown_out_n_holds_rst: assert property (
    !shutdown_out_n_o |-> !reset_out_n_o)
    else $error("Reset high during shutdown");

  a_manual_rst_wins: assert property (
    !manual_reset_n_i |=> !reset_out_n_o)
    else $error("Manual reset did not assert reset");

  a_warn_precedes_shutdown_out_n: assert property (
    $fell(s_reg.shutdown_out_n_n) && !s_reg.wd_sd |-> !$past(s_reg.warn_n))
    else $error("Shutdown without earlier warning");

  a_level_off_trips: assert property (
    !s_reg.ctrl.edge_mode && cmp_i.wake_off && s_reg.sd == SD_RUN
    |=> s_reg.sd == SD_WARN && s_reg.fault[FLT_WAKE])
    else $error("Turn-off crossing not acted on");

  a_edge_ignores_off: assert property (
    s_reg.ctrl.edge_mode && s_reg.sd == SD_RUN |=> s_reg.sd != SD_WARN)
    else $error("Turn-off used in edge mode");

  a_fault_stays: assert property (
    s_reg.fault[FLT_WAKE] && !flt_clr |=> s_reg.fault[FLT_WAKE])
    else $error("Fault bit lost without clear");

  a_main_uv_rst: assert property (
    cmp_i.main_uv |=> !reset_out_n_o ##1 !reset_out_n_o)
    else $error("Undervoltage did not hold reset");

  a_aux_off_quiet: assert property (
    s_reg.ctrl.aux_thr == AUX_THR_OFF |=> s_reg.aux_cnt == 16'h0000)
    else $error("Disabled aux monitor timing reset");

  a_wd_clear_rst: assert property (
    !s_reg.rst_n |=> s_reg.wd_cnt == 16'h0000)
    else $error("Watchdog timer runs under reset");

  a_float_idle: assert property (
    watchdog_float_i && !s_reg.wdog.float_en |=> s_reg.wd_cnt == 16'h0000)
    else $error("Watchdog runs on floating input");

endmodule // smw_supervisor

// >>> shared/smw_pkg.sv
package smw_pkg;

  // ----------------------------------------------------------------
  // Time base and timing tables
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 100;         // System clock rate
  localparam int TICK_US  = 50;          // Time base period in us
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int ONE_SEC_MS = 1000;
  localparam logic [15:0] ONE_SEC_TK = 16'(ONE_SEC_MS * 1000 / TICK_US);
  localparam logic [15:0] WD_PULSE_TK = 16'h0014; // Watchdog reset pulse

  typedef logic [15:0] smw_tbl_t [0:7];
  // All entries in time base ticks
  localparam smw_tbl_t SD_HOLD_TBL = '{16'h0001, 16'h0014, 16'h0064,
    16'h00c8, 16'h0190, 16'h03e8, 16'h07d0, 16'h0fa0};
  localparam smw_tbl_t SD_DLY_TBL = '{16'h0001, 16'h00c8, 16'h03e8,
    16'h07d0, 16'h0fa0, 16'h1f40, 16'h3e80, 16'h5dc0};
  localparam smw_tbl_t RST_HOLD_TBL = '{16'h0002, 16'h0014, 16'h0064,
    16'h00c8, 16'h0190, 16'h03e8, 16'h07d0, 16'h0fa0};
  localparam smw_tbl_t WD_TMO_TBL = '{16'h07d0, 16'h1388, 16'h2710,
    16'h3a98, 16'h4e20, 16'h61a8, 16'h7530, 16'h9c40};

  // ----------------------------------------------------------------
  // Register map and layouts
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_WDOG  = 8'h04;
  localparam logic [7:0] ADR_STAT  = 8'h08;
  localparam logic [7:0] ADR_FAULT = 8'h0c;

  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] aux_hold;
    logic [2:0] aux_thr;
    logic [2:0] main_hold;
    logic [2:0] main_thr;
    logic       edge_mode;
    logic [2:0] sd_delay;
    logic [2:0] sd_hold;
    logic [3:0] off_thr;
    logic [3:0] on_thr;
  } smw_ctrl_s;

  typedef struct packed {
    logic [25:0] rsvd;
    logic        fuse_override;
    logic        float_en;
    logic        adv_mode;
    logic [2:0]  timeout;
  } smw_wdog_s;

  localparam logic [2:0] AUX_THR_OFF = 3'h0; // Aux monitor disabled
  localparam smw_ctrl_s CTRL_RST = '{rsvd: 5'h00, aux_hold: 3'h7,
    aux_thr: AUX_THR_OFF, main_hold: 3'h7, main_thr: 3'h3,
    edge_mode: 1'b0, sd_delay: 3'h3, sd_hold: 3'h3,
    off_thr: 4'h7, on_thr: 4'h8};
  localparam smw_wdog_s WDOG_RST = '{rsvd: 26'h0, fuse_override: 1'b0,
    float_en: 1'b0, adv_mode: 1'b0, timeout: 3'h6};

  localparam int FLT_WAKE = 0; // Fault bit: wake input turned off
  localparam int FLT_WD   = 1; // Fault bit: watchdog timeout

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wake_on;   // Wake input above turn-on threshold
    logic wake_off;  // Wake input below turn-off threshold
    logic main_uv;   // Main supply undervoltage
    logic aux_uv;    // Aux supply undervoltage
  } smw_cmp_s;

  typedef struct packed {
    logic [3:0] wake_turn_on_threshold;
    logic [3:0] wake_turn_off_threshold;
    logic [2:0] main_supply_monitor;
    logic [2:0] aux_supply_monitor;
  } smw_thr_s;

  typedef enum logic [1:0] {SD_RUN, SD_WARN, SD_DOWN} smw_sd_e;

endpackage

// >>> verif/smw_proc_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Processor side: toggles the watchdog line while running
// ----------------------------------------------------------------
module smw_proc_model #(
  parameter int HALF = 1000
) (
  input  wire logic mclk_i,
  input  wire logic run_i,
  output logic      toggle_o = 1'b0
);
  int cnt = 0;

  // Toggle every HALF cycles, hold the line when stopped
  always @(posedge mclk_i) begin
    if (run_i && cnt >= HALF - 1) begin
      cnt      <= 0;
      toggle_o <= ~toggle_o;
    end else if (run_i) begin
      cnt <= cnt + 1;
    end
  end
endmodule // smw_proc_model

// >>> verif/test_smw_supervisor.sv
`timescale 1ns/10ps
module test_smw_supervisor;
  import smw_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i             = 1'b0;
  logic        rst_i              = 1'b1;
  logic        wb_cyc_i           = 1'b0;
  logic        wb_stb_i           = 1'b0;
  logic        wb_we_i            = 1'b0;
  logic [7:0]  wb_adr_i           = 8'h00;
  logic [3:0]  wb_sel_i           = 4'hf;
  logic [31:0] wb_dat_i           = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  smw_cmp_s    cmp_i              = 4'b1000;
  smw_thr_s    thr_o;
  logic        watchdog_toggle_in;
  logic        run                = 1'b1;
  logic        watchdog_float_i   = 1'b0;
  logic        manual_reset_n_i   = 1'b1;
  logic        fuse_float_blown_i = 1'b0;
  logic        shutdown_out_n_o;
  logic        shutdown_warning_n_o;
  logic        reset_out_n_o;
  logic        aux_comparator_out_o;
  logic        aux_comparator_out_oe_o;
  int          errors             = 0;
  int          checks_done        = 0;

  // Clock, 100 MHz
  initial forever #5 mclk_i = ~mclk_i;

  // Short time base keeps the run small: one tick is two clocks
  smw_supervisor #(.TICK_CYCLES(2)) u_smw_supervisor (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .thr_o(thr_o),
    .watchdog_toggle_in_i(watchdog_toggle_in), .watchdog_float_i(watchdog_float_i),
    .manual_reset_n_i(manual_reset_n_i),
    .fuse_float_blown_i(fuse_float_blown_i),
    .shutdown_out_n_o(shutdown_out_n_o),
    .shutdown_warning_n_o(shutdown_warning_n_o),
    .reset_out_n_o(reset_out_n_o),
    .aux_comparator_out_o(aux_comparator_out_o),
    .aux_comparator_out_oe_o(aux_comparator_out_oe_o));

  smw_proc_model u_smw_proc_model (
    .mclk_i(mclk_i), .run_i(run), .toggle_o(watchdog_toggle_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo();
    errors++;
    $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
    finish_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] r;
    wb(1'b1, adr, dat, r);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, adr, 32'h0, r);
    chk(r, exp);
  endtask

  // Wait for reset (sel 0) or shutdown (sel 1) to reach a level
  task automatic wait_lvl(input int sel, input logic lvl, input int max,
                          output int n);
    n = 0;
    while ((sel ? shutdown_out_n_o : reset_out_n_o) !== lvl) begin
      @(posedge mclk_i);
      n++;
      if (n >= max) tmo();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    smw_ctrl_s c;
    int        n;
    int        lows;
    c = CTRL_RST;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_chk(ADR_CTRL, CTRL_RST);
    rd_chk(ADR_WDOG, WDOG_RST);
    rd_chk(8'h10, 32'h0);
    chk(32'(thr_o), 32'({4'h8, 4'h7, 3'h3, 3'h0}));
    c.on_thr    = 4'ha;
    c.off_thr   = 4'h3;
    c.sd_hold   = 3'h0;
    c.sd_delay  = 3'h1;
    c.main_hold = 3'h0;
    c.aux_hold  = 3'h0;
    wr(ADR_CTRL, c);
    rd_chk(ADR_CTRL, c);
    chk(32'(thr_o), 32'({4'ha, 4'h3, 3'h3, 3'h0}));
    wait_lvl(0, 1'b1, 10000, n);
    // Wake input turns off: warning first, shutdown after delay
    cmp_i <= 4'b0100;
    repeat (3) @(posedge mclk_i);
    chk(32'({shutdown_warning_n_o, shutdown_out_n_o}), 32'h1);
    wait_lvl(1, 1'b0, 600, n);
    chk(32'(n > 390 && n < 410), 32'h1);
    chk(32'(reset_out_n_o), 32'h0);
    cmp_i <= 4'b1000;
    wait_lvl(1, 1'b1, 200, n);
    rd_chk(ADR_FAULT, 32'h1);
    rd_chk(ADR_FAULT, 32'h0);
    // Edge mode ignores the turn-off result
    c.edge_mode = 1'b1;
    wr(ADR_CTRL, c);
    cmp_i.wake_off <= 1'b1;
    repeat (50) @(posedge mclk_i);
    chk(32'({shutdown_warning_n_o, shutdown_out_n_o}), 32'h3);
    cmp_i.wake_off <= 1'b0;
    c.edge_mode = 1'b0;
    wr(ADR_CTRL, c);
    // Main undervoltage holds reset until hold expires
    cmp_i.main_uv <= 1'b1;
    repeat (40) @(posedge mclk_i);
    chk(32'({shutdown_out_n_o, reset_out_n_o}), 32'h2);
    cmp_i.main_uv <= 1'b0;
    wait_lvl(0, 1'b1, 60, n);
    chk(32'(n >= 3 && n <= 6), 32'h1);
    // Aux monitor disabled, then enabled
    for (int t = 0; t < 2; t++) begin
      c.aux_thr = 3'(t * 2);
      wr(ADR_CTRL, c);
      cmp_i.aux_uv <= 1'b1;
      @(posedge mclk_i);
      #1;
      chk(32'({aux_comparator_out_oe_o, aux_comparator_out_o}), 32'h2);
      repeat (5) @(posedge mclk_i);
      chk(32'(reset_out_n_o), 32'(t == 0));
      cmp_i.aux_uv <= 1'b0;
      wait_lvl(0, 1'b1, 60, n);
    end
    // Manual reset
    manual_reset_n_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk(32'(reset_out_n_o), 32'h0);
    manual_reset_n_i <= 1'b1;
    wait_lvl(0, 1'b1, 60, n);
    // Float enable locked by blown fuse unless overridden
    fuse_float_blown_i <= 1'b1;
    wr(ADR_WDOG, 32'h10);
    rd_chk(ADR_WDOG, 32'h0);
    // Override must stand before float enable is accepted
    wr(ADR_WDOG, 32'h20);
    wr(ADR_WDOG, 32'h30);
    rd_chk(ADR_WDOG, 32'h30);
    wr(ADR_WDOG, 32'h20);
    wr(ADR_WDOG, 32'h0);
    rd_chk(ADR_WDOG, 32'h0);
    // Standard watchdog: toggling keeps reset high, silence pulses
    lows = 0;
    repeat (6000) begin
      @(posedge mclk_i);
      lows += int'(reset_out_n_o !== 1'b1);
    end
    chk(32'(lows), 32'h0);
    run <= 1'b0;
    wait_lvl(0, 1'b0, 4500, n);
    chk(32'(n > 2900), 32'h1);
    wait_lvl(0, 1'b1, 100, n);
    chk(32'(n > 36 && n < 44), 32'h1);
    wait_lvl(0, 1'b0, 4500, n);
    chk(32'(n > 3900), 32'h1);
    // Advanced watchdog: fourth silent timeout shuts down
    wr(ADR_WDOG, 32'h8);
    wait_lvl(1, 1'b0, 17000, n);
    chk(32'(n > 15000), 32'h1);
    chk(32'(reset_out_n_o), 32'h0);
    rd_chk(ADR_STAT, 32'h2);
    run <= 1'b1;
    finish_test();
  end
endmodule // test_smw_supervisor
